/* File: fod_alarm_cfg.svh */
// Purpose: Timing constants for the fault alarm sequencer
// Assumes: 50 MHz core clock
// Notes:   Times kept in their own units, cycle counts derived
`ifndef FOD_ALARM_CFG_SVH
`define FOD_ALARM_CFG_SVH

`define CLK_HZ          50000000
`define PHASE_S         30
`define TONE_MS         400
`define GAP_MS          800
`define TONE_HZ         2000
`define PHASE_CYC       (`PHASE_S * `CLK_HZ)
`define TONE_CYC        ((`TONE_MS * (`CLK_HZ / 1000)))
`define GAP_CYC         ((`GAP_MS * (`CLK_HZ / 1000)))
`define HALF_TONE_CYC   (`CLK_HZ / (2 * `TONE_HZ))

`endif

/* File: fod_alarm_pkg.sv */
// Purpose: Types for the fault alarm sequencer
// Assumes: Nothing
// Notes:   Timing lives in fod_alarm_cfg.svh
package fod_alarm_pkg;
   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_SOUND  = 2'b01,
      ST_SILENT = 2'b10
   } alarm_state_t;

   typedef struct packed
   {
      logic buzzer;
      logic lamp;
   } alarm_out_t;
endpackage

/* File: tone_gen.sv */
// Purpose: Square wave tone generator for the buzzer pin
// Assumes: enable comes from logic on the same clock
// Notes:   Output low whenever disabled
`timescale 1ns/1ns
`default_nettype none
module tone_gen
#(
   parameter int HALF_CYC = 12500
)
(
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic enable,
   output var  logic tone
);
   localparam int CW = $clog2(HALF_CYC);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

   logic [CW-1:0] cnt;
   wire           wrap = (cnt == LAST);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt  <= '0;
         tone <= 1'b0;
      end
      else if (!enable)
      begin
         cnt  <= '0;
         tone <= 1'b0;
      end
      else
      begin
         cnt  <= wrap ? '0 : cnt + 1'b1;
         tone <= wrap ? ~tone : tone;
      end
   end

   a_tone_idle: assert property
      (@(posedge core_clk) disable iff (!resetn)
         !enable |=> !tone)
      else $error("tone active while disabled");
endmodule
`default_nettype wire

/* File: fod_buzzer_alarm_sequencer.sv */
// Purpose: Buzzer alarm pattern for a major foreign object fault
// Assumes: Fault input arrives from another domain; one 50 MHz clock
// Notes:   Lamp output tracks fast blink for the whole fault duration
`timescale 1ns/1ns
`default_nettype none
`include "fod_alarm_cfg.svh"
module fod_buzzer_alarm_sequencer
   import fod_alarm_pkg::*;
#(
   parameter int PHASE_CYC = `PHASE_CYC,
   parameter int TONE_CYC  = `TONE_CYC,
   parameter int GAP_CYC   = `GAP_CYC,
   parameter int HALF_CYC  = `HALF_TONE_CYC
)
(
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic foreign_object_fault,
   output var  logic buzzer_drive_pin,
   output var  logic red_fault_lamp
);
   localparam int BW = $clog2(TONE_CYC + GAP_CYC);
   localparam int PW = $clog2(PHASE_CYC);
   localparam logic [BW-1:0] BLINK_LAST = BW'(TONE_CYC + GAP_CYC - 1);
   localparam logic [BW-1:0] TONE_END   = BW'(TONE_CYC);
   localparam logic [PW-1:0] PHASE_LAST = PW'(PHASE_CYC - 1);

   logic [2:0]    faultSync;
   logic          fault;
   alarm_state_t  state;
   alarm_state_t  next_state;
   logic [PW-1:0] phaseCnt;
   logic [PW-1:0] next_phaseCnt;
   logic [BW-1:0] blinkCnt;
   logic [BW-1:0] next_blinkCnt;
   alarm_out_t    outs;
   logic          toneWave;

   // Change accepted only once second and third stages agree
   wire agree     = (faultSync[1] == faultSync[2]);
   wire inIdle    = (state == ST_IDLE);
   wire inSound   = (state == ST_SOUND);
   wire phaseWrap = (phaseCnt == PHASE_LAST);
   wire blinkWrap = (blinkCnt == BLINK_LAST);
   // Counters held at zero outside a fault so a new fault starts fresh
   wire holdCnt   = !fault || inIdle;
   // The idle cycle that first sees the fault stays dark, otherwise the
   // opening blink would run one cycle longer than every later one
   wire lampLit   = fault && !inIdle && (blinkCnt < TONE_END);
   wire toneOn    = lampLit && inSound;

   assign next_phaseCnt = (holdCnt || phaseWrap) ? '0 : phaseCnt + 1'b1;
   assign next_blinkCnt = (holdCnt || blinkWrap) ?
                          '0 : blinkCnt + 1'b1;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         faultSync <= 3'h0;
         fault     <= 1'b0;
      end
      else
      begin
         faultSync <= {faultSync[1:0], foreign_object_fault};
         fault     <= agree ? faultSync[2] : fault;
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:   next_state = fault ? ST_SOUND : ST_IDLE;
         ST_SOUND:  next_state = !fault ? ST_IDLE :
                                 phaseWrap ? ST_SILENT : ST_SOUND;
         ST_SILENT: next_state = !fault ? ST_IDLE :
                                 phaseWrap ? ST_SOUND : ST_SILENT;
         default:   next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state    <= ST_IDLE;
         phaseCnt <= '0;
         blinkCnt <= '0;
      end
      else
      begin
         state    <= next_state;
         phaseCnt <= next_phaseCnt;
         blinkCnt <= next_blinkCnt;
      end
   end

   tone_gen #(.HALF_CYC(HALF_CYC)) u_tone
   (
      .core_clk (core_clk),
      .resetn   (resetn),
      .enable   (toneOn),
      .tone     (toneWave)
   );

   // Lamp registered to share the tone generator's one-cycle latency
   // The buzzer field marks the tone window the pin is checked against
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         outs <= '0;
      else
         outs <= '{buzzer: toneOn, lamp: lampLit};
   end

   assign buzzer_drive_pin = toneWave;
   assign red_fault_lamp   = outs.lamp;

   // Synchroniser and alarm start
   a_sync_hold: assert property
      (@(posedge core_clk) disable iff (!resetn)
         !agree |=> $stable(fault))
      else $error("fault moved while stages disagree");
   a_sync_take: assert property
      (@(posedge core_clk) disable iff (!resetn)
         agree |=> fault == $past(faultSync[2]))
      else $error("fault missed an agreed change");
   a_fault_start: assert property
      (@(posedge core_clk) disable iff (!resetn)
         state == ST_IDLE && fault |=> state == ST_SOUND)
      else $error("alarm did not start");

   // Phase sequencing
   a_sound_hold: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && inSound && !phaseWrap |=> inSound)
      else $error("sounding phase cut short");
   a_phase_run: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && !inIdle && !phaseWrap
         |=> phaseCnt == $past(phaseCnt) + 1'b1)
      else $error("phase counter did not advance");
   a_phase_swap: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && $past(fault) && state == ST_SOUND && phaseWrap
         |=> state == ST_SILENT)
      else $error("phase did not alternate");
   a_silent_hold: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && state == ST_SILENT && !phaseWrap |=> state == ST_SILENT)
      else $error("silent phase cut short");
   a_silent_resume: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && state == ST_SILENT && phaseWrap |=> inSound)
      else $error("sounding phase did not resume");
   a_silent_quiet: assert property
      (@(posedge core_clk) disable iff (!resetn)
         state == ST_SILENT |=> !buzzer_drive_pin)
      else $error("buzzer sounding in silent phase");
   a_silent_lamp: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && state == ST_SILENT && blinkCnt < TONE_END
         |=> red_fault_lamp)
      else $error("lamp stopped blinking in silent phase");
   a_tone_sound: assert property
      (@(posedge core_clk) disable iff (!resetn)
         buzzer_drive_pin |-> $past(inSound))
      else $error("tone outside sounding phase");

   // Blink and tone alignment
   a_blink_run: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && !inIdle && !blinkWrap
         |=> blinkCnt == $past(blinkCnt) + 1'b1)
      else $error("blink counter did not advance");
   a_blink_wrap: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && !inIdle && blinkWrap |=> blinkCnt == '0)
      else $error("blink period did not restart");
   a_gap_dark: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && blinkCnt == TONE_END |=> !red_fault_lamp)
      else $error("lamp lit in gap");
   a_lamp_lit: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && !inIdle && blinkCnt < TONE_END |=> red_fault_lamp)
      else $error("lamp dark in tone slot");
   a_gap_quiet: assert property
      (@(posedge core_clk) disable iff (!resetn)
         fault && blinkCnt >= TONE_END |=> !buzzer_drive_pin)
      else $error("tone in quiet gap");
   a_tone_lamp: assert property
      (@(posedge core_clk) disable iff (!resetn)
         buzzer_drive_pin |-> red_fault_lamp)
      else $error("tone without lamp");
   a_tone_window: assert property
      (@(posedge core_clk) disable iff (!resetn)
         buzzer_drive_pin |-> outs.buzzer)
      else $error("tone outside its window");
   a_tone_toggle: assert property
      (@(posedge core_clk) disable iff (!resetn)
         $rose(buzzer_drive_pin) && toneOn ##1 toneOn [*7]
         |-> buzzer_drive_pin)
      else $error("tone half period too short");

   // Clear and restart
   a_clear_idle: assert property
      (@(posedge core_clk) disable iff (!resetn)
         !fault |=> state == ST_IDLE ##1 !buzzer_drive_pin)
      else $error("alarm continued after clear");
   a_clear_dark: assert property
      (@(posedge core_clk) disable iff (!resetn)
         !fault |=> !red_fault_lamp)
      else $error("lamp lit after clear");
   a_idle_reset: assert property
      (@(posedge core_clk) disable iff (!resetn)
         inIdle |=> phaseCnt == '0 && blinkCnt == '0)
      else $error("counters not cleared while idle");
   a_lamp_dark_idle: assert property
      (@(posedge core_clk) disable iff (!resetn)
         state == ST_IDLE && !fault |=> !red_fault_lamp)
      else $error("lamp lit while idle");

   c_sound: cover property (@(posedge core_clk) state == ST_SOUND && toneOn);
   c_silent: cover property (@(posedge core_clk)
      state == ST_SILENT && red_fault_lamp);
   c_resound: cover property (@(posedge core_clk)
      state == ST_SILENT ##1 state == ST_SOUND);
   c_clear: cover property (@(posedge core_clk)
      state == ST_SOUND ##1 state == ST_IDLE);
   c_restart: cover property (@(posedge core_clk)
      state == ST_IDLE && fault ##1 state == ST_SOUND);
endmodule
`default_nettype wire

/* File: buzzer_lamp_model.sv */
// Purpose: Observer for the buzzer and the red fault lamp
// Assumes: Both lines registered on core_clk
// Notes:   Reports each lit interval on the cycle the lamp goes dark
`timescale 1ns/1ns
`default_nettype none
module buzzer_lamp_model
#(
   parameter int HALF = 8
)
(
   input  wire logic        core_clk,
   input  wire logic        buzzer,
   input  wire logic        lamp,
   output wire logic        done,
   output var  logic [15:0] toggles,
   output var  logic [15:0] litLen,
   output var  logic        bad
);
   logic        prevBuz = 1'b0;
   logic        prevLamp = 1'b0;
   logic [15:0] gap = 16'h0;
   wire         rising = buzzer & ~prevBuz;
   initial bad = 1'b0;
   assign done = prevLamp & ~lamp;
   always @(posedge core_clk)
   begin
      prevBuz <= buzzer;
      prevLamp <= lamp;
      gap <= (buzzer != prevBuz) ? 16'h1 : gap + 16'h1;
      if (lamp & ~prevLamp)
         litLen <= 16'h1;
      else if (lamp)
         litLen <= litLen + 16'h1;
      if (lamp & ~prevLamp)
         toggles <= 16'h0;
      else if (lamp && buzzer != prevBuz)
         toggles <= toggles + 16'h1;
      // A tone cut short falls early, so only rising edges are timed
      if (rising && (~lamp & ~prevLamp || lamp && toggles > 1 && gap != HALF))
         bad <= 1'b1;
   end
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench for the fault alarm sequencer
// Assumes: Shortened phase and tone counts
// Notes:   Each lit lamp interval is judged against a queued note
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int HALF = 8;
   localparam int TONE = 32;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        fault = 1'b0;
   logic        buz;
   logic        lamp;
   logic        done;
   logic [15:0] toggles;
   logic [15:0] litLen;
   logic        bad;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   bit          expTone[$];
   always #10 core_clk = ~core_clk;
   fod_buzzer_alarm_sequencer #(.PHASE_CYC(960), .TONE_CYC(TONE),
      .GAP_CYC(64), .HALF_CYC(HALF)) u_dut (.core_clk(core_clk),
      .resetn(resetn), .foreign_object_fault(fault),
      .buzzer_drive_pin(buz), .red_fault_lamp(lamp));
   buzzer_lamp_model #(.HALF(HALF)) u_model (.core_clk(core_clk),
      .buzzer(buz), .lamp(lamp), .done(done), .toggles(toggles),
      .litLen(litLen), .bad(bad));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic note_tones(input int n, input bit tone);
      repeat (n) expTone.push_back(tone);
   endtask
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         fail_count++;
         end_of_test();
      end
      if (done)
      begin
         check(toggles != 0, expTone.pop_front());
         check(litLen, TONE);
      end
   end
   initial
   begin
      void'($urandom(32'h7E7B));
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      check(buz, 1'b0);
      note_tones(10, 1'b1);
      note_tones(10, 1'b0);
      note_tones(10, 1'b1);
      note_tones(3, 1'b0);
      fault = 1'b1;
      while (expTone.size() != 0)
         @(negedge core_clk);
      // Drop inside a silent-phase gap so that a restart must sound again
      repeat ($urandom_range(30)) @(negedge core_clk);
      fault = 1'b0;
      repeat (8) @(negedge core_clk);
      check(buz, 1'b0);
      check(lamp, 1'b0);
      note_tones(2, 1'b1);
      fault = 1'b1;
      while (expTone.size() != 0)
         @(negedge core_clk);
      check(bad, 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
